// ===== core/flash_iap_pkg.sv
// package for the flash in-application access controller
// assumes an 8051-style core presenting decoded move requests on sys_clk
package flash_iap_pkg;
	// ---------------------------------------------------------------
	// sfr offsets and codes
	// ---------------------------------------------------------------
	localparam logic [7:0] SOFT_COMMAND_ADDR = 8'h97;
	localparam logic [7:0] INT_ENABLE_GROUP1_ADDR = 8'hA9;
	localparam logic [7:0] CONFIG_WORD_LOW_SFR_ADDR = 8'hF7;
	localparam logic [7:0] UNLOCK_CODE = 8'h65;
	localparam logic [7:0] SOFT_RESET_CODE = 8'h56;
	localparam logic [7:0] INT_ENABLE_GROUP1_RESET = 8'h00;
	localparam logic [2:0] SELF_WRITE_ENABLE_CODE = 3'b101;
	localparam int SELF_WRITE_ENABLE_LSB = 5;
	localparam int CODE_READ_LOCK_BIT = 5;
	// ---------------------------------------------------------------
	// flash map
	// ---------------------------------------------------------------
	localparam logic [15:0] LOCK_AREA_LAST = 16'h01FF;
	localparam logic [15:0] FREE_AREA_FIRST = 16'h7F00;
	localparam logic [15:0] FREE_AREA_LAST = 16'h7FFD;
	localparam logic [15:0] CONFIG_LOW_ADDR = 16'h7FFE;
	localparam logic [15:0] CONFIG_HIGH_ADDR = 16'h7FFF;
	localparam logic [15:0] FLASH_LAST = 16'h7FFF;
	localparam logic [15:0] EXT_RAM_FIRST = 16'hF800;
	// ---------------------------------------------------------------
	// data memory map
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_BANK_LAST = 8'h1F;
	localparam logic [7:0] BIT_AREA_FIRST = 8'h20;
	localparam logic [7:0] BIT_AREA_LAST = 8'h2F;
	localparam logic [7:0] SFR_FIRST = 8'h80;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int SYS_CLK_MHZ = 100;
	localparam int FLASH_WRITE_TIME_US = 500;
	localparam int FLASH_WRITE_CYCLES = FLASH_WRITE_TIME_US * SYS_CLK_MHZ;
	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WRITE = 2'b01,
		ST_LOAD = 2'b10
	} iap_state_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] addr;
		logic [7:0] data;
	} ext_req_t;

	typedef struct packed {
		logic write;
		logic [15:0] addr;
		logic [7:0] data;
	} flash_cmd_t;

	typedef struct packed {
		logic internal_ram;
		logic reg_bank;
		logic bit_area;
		logic sfr;
	} data_sel_t;
endpackage : flash_iap_pkg

// ===== core/flash_region_check.sv
// region permission check for flash moves
// assumes addresses up to 7FFFh belong to flash
`timescale 1ns/1ps
`default_nettype none
module flash_region_check
	import flash_iap_pkg::*;
(
	// request
	input wire logic [15:0] addr,
	input wire logic code_read_lock,
	input wire logic wide_write_unlock,
	// verdict
	output logic code_read_ok,
	output logic data_move_ok,
	output logic in_flash
);
	always_comb begin
		in_flash = (addr <= FLASH_LAST);
		code_read_ok = in_flash;
		data_move_ok = 1'b0;
		if (addr <= LOCK_AREA_LAST) begin
			code_read_ok = !code_read_lock;
			data_move_ok = !code_read_lock && wide_write_unlock;
		end else if (addr >= FREE_AREA_FIRST && addr <= FREE_AREA_LAST) begin
			data_move_ok = 1'b1;
		end else if (addr == CONFIG_LOW_ADDR) begin
			data_move_ok = wide_write_unlock;
		end else if (addr == CONFIG_HIGH_ADDR) begin
			data_move_ok = 1'b0;
		end else if (in_flash) begin
			data_move_ok = wide_write_unlock;
		end
	end
endmodule : flash_region_check
`default_nettype wire

// ===== core/flash_iap_access_control.sv
// flash in-application access controller with data memory decode
// assumes the core stalls while cpu_wait is high and holds its request
// Operation
// - lock area gated by lock and unlock
// - main area: code reads free, data moves need unlock
// - free area always readable and writable
// - config high never, low needs unlock
// - 65h sets unlock, others clear it
// - soft command read returns unlock flag
// - self-write enabled only by field 101
// - external write starts flash byte write
// - cpu waits 500 us, peripherals run
// - interrupts held pending during write
// - flash reads add no wait cycles
// - config low copied to sfr after reset
// - external ram decoded at F800h upward
// - indirect reaches 256 bytes, direct 128
// - bit area 20h-2Fh, banks 00h-1Fh
// - sfrs occupy upper direct space
// - writing 56h requests software reset
`timescale 1ns/1ps
`default_nettype none
module flash_iap_access_control
	import flash_iap_pkg::*;
#(
	parameter int WRITE_CYCLES = FLASH_WRITE_CYCLES
)(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// sfr bus from the core
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// external data move request, data_pointer as address
	input wire ext_req_t ext_req,
	// code read request
	input wire logic code_rd,
	input wire logic [15:0] code_addr,
	// internal data access decode request
	input wire logic [7:0] data_addr,
	input wire logic data_indirect,
	output data_sel_t data_sel,
	// flash array
	input wire logic [7:0] flash_rdata,
	input wire logic config_valid,
	input wire logic [7:0] config_high_byte,
	input wire logic [7:0] config_low_byte,
	output flash_cmd_t flash_cmd,
	output logic flash_write_busy,
	// core control
	output logic cpu_wait,
	output logic irq_hold,
	output logic code_read_deny,
	output logic ext_read_deny,
	output logic ext_ram_sel,
	output logic [7:0] read_data,
	output logic soft_reset_req,
	output logic [7:0] config_low_sfr
);
	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic wide_write_unlock_q;
	logic [7:0] int_enable_group1_q;
	logic code_read_lock_q;
	logic [7:0] config_low_q;
	logic config_loaded_q;
	iap_state_t state_q;
	logic [31:0] wait_cnt_q;
	flash_cmd_t flash_cmd_q;
	logic cpu_wait_q;
	logic soft_reset_q;
	logic [7:0] sfr_rdata_q;
	logic [7:0] read_data_q;
	logic code_deny_q;
	logic ext_deny_q;
	logic ext_ram_q;
	data_sel_t data_sel_q;

	logic self_write_enable;
	logic ext_move_ok;
	logic ext_in_flash;
	logic code_ok;
	logic code_in_flash;
	logic write_start;

	assign self_write_enable =
		(int_enable_group1_q[SELF_WRITE_ENABLE_LSB +: 3] == SELF_WRITE_ENABLE_CODE);

	flash_region_check ext_check (
		.addr(ext_req.addr),
		.code_read_lock(code_read_lock_q),
		.wide_write_unlock(wide_write_unlock_q),
		.code_read_ok(),
		.data_move_ok(ext_move_ok),
		.in_flash(ext_in_flash)
	);

	flash_region_check code_check (
		.addr(code_addr),
		.code_read_lock(code_read_lock_q),
		.wide_write_unlock(wide_write_unlock_q),
		.code_read_ok(code_ok),
		.data_move_ok(),
		.in_flash(code_in_flash)
	);

	// a denied write falls through without starting anything
	assign write_start = (state_q == ST_IDLE) && ext_req.valid && ext_req.write
		&& ext_in_flash && ext_move_ok && self_write_enable;

	// ---------------------------------------------------------------
	// data memory decode
	// ---------------------------------------------------------------
	function automatic data_sel_t decode_data(input logic [7:0] a, input logic ind);
		data_sel_t s;
		s.internal_ram = ind || (a < SFR_FIRST);
		s.reg_bank = s.internal_ram && (a <= REG_BANK_LAST);
		s.bit_area = !ind && a >= BIT_AREA_FIRST && a <= BIT_AREA_LAST;
		s.sfr = !ind && (a >= SFR_FIRST);
		return s;
	endfunction : decode_data

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			data_sel_q <= '0;
			ext_ram_q <= 1'b0;
		end else begin
			data_sel_q <= decode_data(data_addr, data_indirect);
			ext_ram_q <= ext_req.valid && (ext_req.addr >= EXT_RAM_FIRST);
		end
	end

	// ---------------------------------------------------------------
	// soft command and unlock flag
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wide_write_unlock_q <= 1'b0;
			soft_reset_q <= 1'b0;
		end else begin
			soft_reset_q <= 1'b0;
			if (sfr_wr && sfr_addr == SOFT_COMMAND_ADDR) begin
				wide_write_unlock_q <= (sfr_wdata == UNLOCK_CODE);
				soft_reset_q <= (sfr_wdata == SOFT_RESET_CODE);
			end
		end
	end

	// ---------------------------------------------------------------
	// interrupt enable group and config low sfr
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			int_enable_group1_q <= INT_ENABLE_GROUP1_RESET;
		end else if (sfr_wr && sfr_addr == INT_ENABLE_GROUP1_ADDR) begin
			int_enable_group1_q <= sfr_wdata;
		end
	end

	// config bytes load once the array reports them valid after reset
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			config_loaded_q <= 1'b0;
			config_low_q <= 8'h00;
			code_read_lock_q <= 1'b1;
		end else if (!config_loaded_q) begin
			if (config_valid) begin
				config_loaded_q <= 1'b1;
				config_low_q <= config_low_byte;
				code_read_lock_q <= config_high_byte[CODE_READ_LOCK_BIT];
			end
		end else if (sfr_wr && sfr_addr == CONFIG_WORD_LOW_SFR_ADDR) begin
			config_low_q <= sfr_wdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sfr_rdata_q <= 8'h00;
		end else if (sfr_rd) begin
			if (sfr_addr == SOFT_COMMAND_ADDR) begin
				sfr_rdata_q <= {7'b000_0000, wide_write_unlock_q};
			end else if (sfr_addr == INT_ENABLE_GROUP1_ADDR) begin
				sfr_rdata_q <= int_enable_group1_q;
			end else if (sfr_addr == CONFIG_WORD_LOW_SFR_ADDR) begin
				sfr_rdata_q <= config_low_q;
			end else begin
				sfr_rdata_q <= 8'h00;
			end
		end
	end

	// ---------------------------------------------------------------
	// write sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_q <= ST_IDLE;
			wait_cnt_q <= 32'h0000_0000;
			flash_cmd_q <= '0;
			cpu_wait_q <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					flash_cmd_q.write <= 1'b0;
					if (write_start) begin
						state_q <= ST_WRITE;
						flash_cmd_q.write <= 1'b1;
						flash_cmd_q.addr <= ext_req.addr;
						flash_cmd_q.data <= ext_req.data;
						wait_cnt_q <= 32'(WRITE_CYCLES - 1);
						cpu_wait_q <= 1'b1;
					end
				end
				ST_WRITE: begin
					flash_cmd_q.write <= 1'b0;
					if (wait_cnt_q == 32'h0000_0000) begin
						state_q <= ST_IDLE;
						cpu_wait_q <= 1'b0;
					end else begin
						wait_cnt_q <= wait_cnt_q - 32'h0000_0001;
					end
				end
				default: begin
					state_q <= ST_IDLE;
					cpu_wait_q <= 1'b0;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// read path, no wait inserted
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			read_data_q <= 8'h00;
			code_deny_q <= 1'b0;
			ext_deny_q <= 1'b0;
		end else begin
			code_deny_q <= code_rd && code_in_flash && !code_ok;
			ext_deny_q <= ext_req.valid && !ext_req.write && ext_in_flash
				&& !ext_move_ok;
			if ((code_rd && code_ok) || (ext_req.valid && !ext_req.write
					&& ext_in_flash && ext_move_ok)) begin
				read_data_q <= flash_rdata;
			end else begin
				read_data_q <= 8'h00;
			end
		end
	end

	assign sfr_rdata = sfr_rdata_q;
	assign data_sel = data_sel_q;
	assign flash_cmd = flash_cmd_q;
	assign flash_write_busy = cpu_wait_q;
	assign cpu_wait = cpu_wait_q;
	assign irq_hold = cpu_wait_q;
	assign code_read_deny = code_deny_q;
	assign ext_read_deny = ext_deny_q;
	assign ext_ram_sel = ext_ram_q;
	assign read_data = read_data_q;
	assign soft_reset_req = soft_reset_q;
	assign config_low_sfr = config_low_q;
endmodule : flash_iap_access_control
`default_nettype wire

// ===== tb/flash_iap_props.sv
// assertions on the flash access controller ports
// bound to the controller top; write count handed on from the instance
`timescale 1ns/1ps
`default_nettype none
module flash_iap_props
	import flash_iap_pkg::*;
#(
	parameter int WRITE_CYCLES = FLASH_WRITE_CYCLES
)(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// watched ports
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire ext_req_t ext_req,
	input wire logic code_rd,
	input wire logic [15:0] code_addr,
	input wire logic [7:0] data_addr,
	input wire logic data_indirect,
	input wire data_sel_t data_sel,
	input wire logic [7:0] config_high_byte,
	input wire flash_cmd_t flash_cmd,
	input wire logic flash_write_busy,
	input wire logic cpu_wait,
	input wire logic irq_hold,
	input wire logic code_read_deny,
	input wire logic ext_ram_sel,
	input wire logic soft_reset_req
);
	int wait_cnt;
	logic unlock_q;
	logic swe_q;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	always_ff @(posedge sys_clk) begin
		if (reset || !cpu_wait)
			wait_cnt <= 0;
		else
			wait_cnt <= wait_cnt + 1;
	end
	// shadow flags from sfr writes
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			unlock_q <= 1'b0;
			swe_q <= 1'b0;
		end else if (sfr_wr && sfr_addr == SOFT_COMMAND_ADDR) begin
			unlock_q <= sfr_wdata == UNLOCK_CODE;
		end else if (sfr_wr && sfr_addr == INT_ENABLE_GROUP1_ADDR) begin
			swe_q <= sfr_wdata[7:5] == SELF_WRITE_ENABLE_CODE;
		end
	end
	wait_length_a: assert property ($fell(cpu_wait) |-> wait_cnt == WRITE_CYCLES)
		else $error("cpu wait length wrong");
	wait_mirror_a: assert property (irq_hold == cpu_wait && flash_write_busy == cpu_wait)
		else $error("irq hold differs from wait");
	cmd_pulse_a: assert property (flash_cmd.write |-> $rose(cpu_wait) ##1 !flash_cmd.write)
		else $error("write pulse malformed");
	denied_nowait_a: assert property (ext_req.valid && ext_req.write && !cpu_wait
		&& (!swe_q || ext_req.addr == CONFIG_HIGH_ADDR) |=> !cpu_wait)
		else $error("denied write stalled core");
	unlock_read_a: assert property (sfr_rd && !sfr_wr && sfr_addr == SOFT_COMMAND_ADDR
		|=> sfr_rdata == {7'h00, $past(unlock_q)})
		else $error("unlock flag read wrong");
	soft_reset_a: assert property (sfr_wr && sfr_addr == SOFT_COMMAND_ADDR
		&& sfr_wdata == SOFT_RESET_CODE |=> soft_reset_req)
		else $error("soft reset missing");
	lock_deny_a: assert property (code_rd && code_addr <= LOCK_AREA_LAST
		&& config_high_byte[CODE_READ_LOCK_BIT] |=> code_read_deny)
		else $error("locked code read allowed");
	ext_ram_a: assert property (ext_req.valid && ext_req.addr >= EXT_RAM_FIRST |=> ext_ram_sel)
		else $error("ext ram not selected");
	sfr_direct_a: assert property (!data_indirect && data_addr >= SFR_FIRST |=> data_sel.sfr)
		else $error("sfr decode wrong");
endmodule : flash_iap_props
bind flash_iap_access_control flash_iap_props #(.WRITE_CYCLES(WRITE_CYCLES)) i_props (
	.sys_clk(sys_clk), .reset(reset), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
	.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .ext_req(ext_req), .code_rd(code_rd),
	.code_addr(code_addr), .data_addr(data_addr), .data_indirect(data_indirect),
	.data_sel(data_sel), .config_high_byte(config_high_byte), .flash_cmd(flash_cmd),
	.flash_write_busy(flash_write_busy), .cpu_wait(cpu_wait), .irq_hold(irq_hold),
	.code_read_deny(code_read_deny), .ext_ram_sel(ext_ram_sel), .soft_reset_req(soft_reset_req));
`default_nettype wire

// ===== tb/flash_array_model.sv
// behavioural flash array behind the controller
// assumes the bench presents the current read address
`timescale 1ns/1ps
`default_nettype none
module flash_array_model
	import flash_iap_pkg::*;
(
	// clock and read address
	input wire logic sys_clk,
	input wire logic [15:0] rd_addr,
	// controller side
	input wire flash_cmd_t flash_cmd,
	output logic [7:0] flash_rdata,
	output logic config_valid,
	output logic [7:0] config_high_byte,
	output logic [7:0] config_low_byte
);
	logic [7:0] mem [0:32767];
	// contents follow address xor 5Ah; high config byte sets the lock
	initial begin
		for (int i = 0; i < 32768; i++)
			mem[i] = 8'(i) ^ 8'h5A;
		mem[32767] = 8'h20;
	end
	assign flash_rdata = mem[rd_addr[14:0]];
	assign config_valid = 1'b1;
	assign config_high_byte = mem[32767];
	assign config_low_byte = mem[32766];
	always @(posedge sys_clk) begin
		if (flash_cmd.write)
			mem[flash_cmd.addr[14:0]] <= flash_cmd.data;
	end
endmodule : flash_array_model
`default_nettype wire

// ===== tb/flash_iap_access_control_tb.sv
// self-checking bench for the flash access controller
// assumes the array model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module flash_iap_access_control_tb
	import flash_iap_pkg::*;
;
	localparam int WC = 8;
	typedef struct packed {logic [7:0] a; logic ind; data_sel_t sel;} row_t;
	row_t rows [6] = '{'{8'h05, 1'b0, 4'hC}, '{8'h2A, 1'b0, 4'hA}, '{8'h7F, 1'b0, 4'h8},
		'{8'h90, 1'b0, 4'h1}, '{8'h90, 1'b1, 4'h8}, '{8'h1F, 1'b1, 4'hC}};
	logic sys_clk, reset, sfr_wr, sfr_rd, code_rd, data_indirect, config_valid, flash_write_busy;
	logic cpu_wait, irq_hold, code_read_deny, ext_read_deny, ext_ram_sel, soft_reset_req;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, data_addr, flash_rdata, read_data;
	logic [7:0] config_high_byte, config_low_byte, config_low_sfr;
	logic [15:0] code_addr;
	ext_req_t ext_req;
	data_sel_t data_sel;
	flash_cmd_t flash_cmd;
	int n_errors, check_count;
	flash_iap_access_control #(.WRITE_CYCLES(WC)) i_dut (.sys_clk(sys_clk), .reset(reset),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .ext_req(ext_req), .code_rd(code_rd), .code_addr(code_addr),
		.data_addr(data_addr), .data_indirect(data_indirect), .data_sel(data_sel),
		.flash_rdata(flash_rdata), .config_valid(config_valid), .config_high_byte(config_high_byte),
		.config_low_byte(config_low_byte), .flash_cmd(flash_cmd), .flash_write_busy(flash_write_busy),
		.cpu_wait(cpu_wait), .irq_hold(irq_hold), .code_read_deny(code_read_deny),
		.ext_read_deny(ext_read_deny), .ext_ram_sel(ext_ram_sel), .read_data(read_data),
		.soft_reset_req(soft_reset_req), .config_low_sfr(config_low_sfr));
	flash_array_model i_flash (.sys_clk(sys_clk), .rd_addr(code_rd ? code_addr : ext_req.addr),
		.flash_cmd(flash_cmd), .flash_rdata(flash_rdata), .config_valid(config_valid),
		.config_high_byte(config_high_byte), .config_low_byte(config_low_byte));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test
	task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk) {sfr_wr, sfr_addr, sfr_wdata} <= {1'b1, a, d};
		@(posedge sys_clk) sfr_wr <= 1'b0;
	endtask : sfr_w
	task automatic sfr_r(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk) {sfr_rd, sfr_addr} <= {1'b1, a};
		@(posedge sys_clk) sfr_rd <= 1'b0;
		#1 chk("sfr_rdata", exp, sfr_rdata);
	endtask : sfr_r
	task automatic code_r(input logic [15:0] a, input logic deny, input logic [7:0] d);
		@(posedge sys_clk) {code_rd, code_addr} <= {1'b1, a};
		@(posedge sys_clk) code_rd <= 1'b0;
		#1 chk("code_read_deny", deny, code_read_deny);
		chk("read_data", deny ? 8'h00 : d, read_data);
	endtask : code_r
	task automatic ext(input logic w, input logic [15:0] a, input logic [7:0] d, input int n_exp);
		int n;
		@(posedge sys_clk) ext_req <= '{1'b1, w, a, d};
		@(posedge sys_clk) ext_req.valid <= 1'b0;
		#1 chk("ext_ram_sel", a >= EXT_RAM_FIRST, ext_ram_sel);
		chk("flash_cmd.write", n_exp != 0, flash_cmd.write);
		n = 0;
		while (cpu_wait && n < 100) begin
			n++;
			@(posedge sys_clk) #1;
		end
		chk("wait cycles", 16'(n_exp), 16'(n));
		if (n == 100)
			finish_test();
	endtask : ext
	task automatic ext_r(input logic [15:0] a, input logic deny, input logic [7:0] d);
		@(posedge sys_clk) ext_req <= '{1'b1, 1'b0, a, 8'h00};
		@(posedge sys_clk) ext_req.valid <= 1'b0;
		#1 chk("ext_read_deny", deny, ext_read_deny);
		chk("read_data", deny ? 8'h00 : d, read_data);
	endtask : ext_r
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		{reset, sfr_wr, sfr_rd, code_rd, data_indirect} = 5'h1F;
		{sfr_rd, code_rd, data_indirect, sfr_wr} = 4'h0;
		{sfr_addr, sfr_wdata, data_addr, code_addr, ext_req} = '0;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk) #1 chk("cpu_wait", 1'b0, cpu_wait);
		chk("sfr_rdata", 8'h00, sfr_rdata);
		repeat (3) @(posedge sys_clk);
		#1 chk("config_low_sfr", 8'hA4, config_low_sfr);
		$display("test reset done");
		foreach (rows[i]) begin
			@(posedge sys_clk) {data_addr, data_indirect} <= {rows[i].a, rows[i].ind};
			@(posedge sys_clk) #1 chk("data_sel", 4'(rows[i].sel), 4'(data_sel));
		end
		$display("test data map done");
		sfr_r(SOFT_COMMAND_ADDR, 8'h00);
		sfr_w(SOFT_COMMAND_ADDR, UNLOCK_CODE);
		sfr_r(SOFT_COMMAND_ADDR, 8'h01);
		sfr_w(SOFT_COMMAND_ADDR, SOFT_RESET_CODE);
		#1 chk("soft_reset_req", 1'b1, soft_reset_req);
		sfr_r(SOFT_COMMAND_ADDR, 8'h00);
		sfr_r(8'h00, 8'h00);
		$display("test soft command done");
		code_r(16'h0100, 1'b1, 8'h00);
		code_r(16'h0345, 1'b0, 8'h1F);
		code_r(16'h7FFF, 1'b0, 8'h20);
		$display("test code reads done");
		ext(1'b1, 16'h7F00, 8'hC3, 0);
		sfr_w(INT_ENABLE_GROUP1_ADDR, 8'h80);
		ext(1'b1, 16'h7F00, 8'hC3, 0);
		sfr_w(INT_ENABLE_GROUP1_ADDR, 8'hA0);
		ext(1'b1, 16'h7F00, 8'hC3, WC);
		ext(1'b1, 16'h0345, 8'h11, 0);
		sfr_w(SOFT_COMMAND_ADDR, UNLOCK_CODE);
		ext(1'b1, 16'h7FFF, 8'h11, 0);
		ext(1'b1, 16'h0010, 8'h11, 0);
		ext(1'b1, 16'h0345, 8'h11, WC);
		sfr_w(SOFT_COMMAND_ADDR, 8'h00);
		sfr_w(INT_ENABLE_GROUP1_ADDR, 8'h00);
		code_r(16'h7F00, 1'b0, 8'hC3);
		code_r(16'h0345, 1'b0, 8'h11);
		ext_r(16'h7F00, 1'b0, 8'hC3);
		ext_r(16'h7FFF, 1'b1, 8'h00);
		ext_r(16'h0010, 1'b1, 8'h00);
		ext(1'b0, 16'hF900, 8'h00, 0);
		$display("test flash writes done");
		sfr_w(SOFT_COMMAND_ADDR, UNLOCK_CODE);
		sfr_w(INT_ENABLE_GROUP1_ADDR, 8'hA0);
		@(posedge sys_clk) reset <= 1'b1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		sfr_r(SOFT_COMMAND_ADDR, 8'h00);
		sfr_r(INT_ENABLE_GROUP1_ADDR, 8'h00);
		ext(1'b1, 16'h7F00, 8'h3C, 0);
		$display("test mid reset done");
		finish_test();
	end
endmodule : flash_iap_access_control_tb
`default_nettype wire
